// ---- hdl/eraf_filter.sv ----
// Function
// - a non-secure requester never sees secure, realm or root confidential record content.
// - a secure requester never sees realm or root confidential record content.
// - a realm requester never sees secure or root confidential record content.
// - a root requester has nothing withheld and reads every field unfiltered.
// - record content is owned by the space of its memory data or the state of its execution context.
// - data the granule protection table forbids, and context from another state, count as confidential.
// - the detected error address is open to every requester.
// - field replaceable unit information in the miscellaneous register is open to every requester.
// - status contents and the error counter are open to every requester.
// - node properties, identification and affinity are open to every requester.
// - a record holding several spaces or states shapes what it returns by the requester's state.
// - in root-only mode memory-mapped record registers accept only root accesses.
// - with the error_record_trap_control bit set, system register accesses from non-root states are blocked.
// - content filtering is the default and root-only mode must be chosen explicitly.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
module eraf_filter #(
  parameter int          ADDR_W  = 32,
  parameter logic [31:0] NODE_ID = 32'h0000_0a5c  // arbitrary node identification value
) (
  input  wire logic              ref_clk_i,
  input  wire logic              sys_rst_i,
  // ahb-lite slave
  input  wire logic              hsel_i,
  input  wire logic [ADDR_W-1:0] haddr_i,
  input  wire logic [1:0]        htrans_i,
  input  wire logic              hwrite_i,
  input  wire logic [2:0]        hsize_i,
  input  wire logic [31:0]       hwdata_i,
  input  wire logic              hready_i,
  output logic                   hreadyout_o,
  output logic                   hresp_o,
  output logic [31:0]            hrdata_o,
  // requester tag, taken with the address phase
  input  wire logic [1:0]        req_sec_i,
  input  wire logic              req_sysreg_i,
  // error capture from the detecting hardware
  input  wire logic              err_valid_i,
  input  wire logic [31:0]       err_addr_i,
  input  wire logic [31:0]       err_data_i,
  input  wire logic [31:0]       err_ctx_i,
  input  wire logic [1:0]        err_space_i,
  input  wire logic [1:0]        err_state_i,
  input  wire logic              err_gpt_deny_i,
  input  wire logic [15:0]       err_fru_i,
  input  wire logic [15:0]       err_syn_i,
  input  wire logic [2:0]        err_sev_i,
  // current mode for the surrounding system
  output logic                   root_only_o,
  output logic                   trap_ctrl_o
);

  // record and control state
  eraf_pkg::eraf_state_t state_r;
  eraf_pkg::eraf_state_t state_nxt;
  logic [7:0]  a_ofs_r;
  logic [1:0]  a_sec_r;
  logic        a_sys_r;
  logic        a_word_r;
  logic        valid_r;
  logic        ovf_r;
  logic [2:0]  sev_r;
  logic [1:0]  space_r;
  logic [1:0]  origin_r;
  logic        gpt_r;
  logic [31:0] addr_r;
  logic [31:0] data_r;
  logic [31:0] ctx_r;
  logic [15:0] fru_r;
  logic [15:0] syn_r;
  logic [31:0] count_r;
  logic [1:0]  ctrl_r;
  logic [31:0] hrdata_r;

  // address phase acceptance
  wire acc      = hsel_i && hready_i && (htrans_i == eraf_pkg::HTRANS_NONSEQ);
  wire is_root  = (a_sec_r == eraf_pkg::SEC_ROOT);
  wire root_only = ctrl_r[eraf_pkg::CTRL_ROOTONLY_BIT];
  wire trap_on  = ctrl_r[eraf_pkg::CTRL_TRAP_BIT];

  // register decode
  wire hit_stat  = (a_ofs_r == eraf_pkg::OFS_STATUS);
  wire hit_addr  = (a_ofs_r == eraf_pkg::OFS_ADDR);
  wire hit_misc  = (a_ofs_r == eraf_pkg::OFS_MISC);
  wire hit_count = (a_ofs_r == eraf_pkg::OFS_COUNT);
  wire hit_data  = (a_ofs_r == eraf_pkg::OFS_DATA);
  wire hit_ctx   = (a_ofs_r == eraf_pkg::OFS_CTX);
  wire hit_node  = (a_ofs_r == eraf_pkg::OFS_NODE);
  wire hit_ctrl  = (a_ofs_r == eraf_pkg::OFS_CTRL);

  // blocking: root-only mode for memory-mapped, trap for system register path
  wire blk_mmio = root_only && !a_sys_r && !is_root;
  wire blk_trap = trap_on && a_sys_r && !is_root;
  wire blk      = (blk_mmio || blk_trap) && !hit_ctrl;

  // visibility by owner: root sees all, own state and non-secure are visible, data only where the granule protection table allows it
  wire vis_space = is_root || (space_r == a_sec_r) || (space_r == eraf_pkg::SEC_NONSEC);
  wire vis_state = is_root || (origin_r == a_sec_r) || (origin_r == eraf_pkg::SEC_NONSEC);
  wire vis_data  = vis_space && (is_root || !gpt_r);
  wire vis_ctx   = vis_state;

  // record words as seen by the current requester
  wire [31:0] stat_word = {19'h0, gpt_r, origin_r, space_r, 1'b0, sev_r, 2'h0, ovf_r, valid_r};
  wire [31:0] misc_word = {(vis_ctx ? syn_r : 16'h0000), fru_r};
  wire [31:0] data_word = vis_data ? data_r : eraf_pkg::WORD_ZERO;
  wire [31:0] ctx_word  = vis_ctx ? ctx_r : eraf_pkg::WORD_ZERO;
  wire [31:0] ctrl_word = {30'h0, ctrl_r};

  // read selection; unmapped and blocked reads return zero
  wire [31:0] rd_sel = ({32{hit_stat}}  & stat_word)
                     | ({32{hit_addr}}  & addr_r)
                     | ({32{hit_misc}}  & misc_word)
                     | ({32{hit_count}} & count_r)
                     | ({32{hit_data}}  & data_word)
                     | ({32{hit_ctx}}   & ctx_word)
                     | ({32{hit_node}}  & NODE_ID)
                     | ({32{hit_ctrl}}  & ctrl_word);
  wire [31:0] rd_word = blk ? eraf_pkg::WORD_ZERO : rd_sel;

  // write strobes; blocked writes have no effect
  wire wr_ok    = (state_r == eraf_pkg::ST_WRITE) && a_word_r && !blk;
  wire wr_stat  = wr_ok && hit_stat;
  wire wr_count = wr_ok && hit_count;
  wire wr_ctrl  = wr_ok && hit_ctrl && is_root;
  wire clr_valid = wr_stat && hwdata_i[eraf_pkg::STAT_VALID_BIT];
  wire clr_ovf   = wr_stat && hwdata_i[eraf_pkg::STAT_OVF_BIT];

  // next slave state
  always_comb begin
    state_nxt = eraf_pkg::ST_IDLE;
    unique case (state_r)
      eraf_pkg::ST_RDWAIT: begin
        state_nxt = eraf_pkg::ST_RDDONE;
      end
      eraf_pkg::ST_IDLE, eraf_pkg::ST_WRITE, eraf_pkg::ST_RDDONE: begin
        if (acc) begin
          state_nxt = hwrite_i ? eraf_pkg::ST_WRITE : eraf_pkg::ST_RDWAIT;
        end
      end
      default: begin
        state_nxt = eraf_pkg::ST_IDLE;
      end
    endcase
  end

  // slave state and address phase capture with requester tag
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r  <= eraf_pkg::ST_IDLE;
      a_ofs_r  <= 8'h00;
      a_sec_r  <= eraf_pkg::SEC_NONSEC;
      a_sys_r  <= 1'b0;
      a_word_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (acc) begin
        a_ofs_r  <= haddr_i[eraf_pkg::OFS_W-1:0];
        a_sec_r  <= req_sec_i;
        a_sys_r  <= req_sysreg_i;
        a_word_r <= (hsize_i == eraf_pkg::HSIZE_WORD);
      end
    end
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_r <= eraf_pkg::WORD_ZERO;
    end else if (state_r == eraf_pkg::ST_RDWAIT) begin
      hrdata_r <= rd_word;
    end
  end

  // error capture; a new error wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_r  <= 1'b0;
      ovf_r    <= 1'b0;
      sev_r    <= 3'h0;
      space_r  <= eraf_pkg::SEC_NONSEC;
      origin_r <= eraf_pkg::SEC_NONSEC;
      gpt_r    <= 1'b0;
      addr_r   <= eraf_pkg::WORD_ZERO;
      data_r   <= eraf_pkg::WORD_ZERO;
      ctx_r    <= eraf_pkg::WORD_ZERO;
      fru_r    <= 16'h0000;
      syn_r    <= 16'h0000;
    end else if (err_valid_i && !(valid_r && !clr_valid)) begin
      valid_r  <= 1'b1;
      ovf_r    <= ovf_r && !clr_ovf;
      sev_r    <= err_sev_i;
      space_r  <= err_space_i;
      origin_r <= err_state_i;
      gpt_r    <= err_gpt_deny_i;
      addr_r   <= err_addr_i;
      data_r   <= err_data_i;
      ctx_r    <= err_ctx_i;
      fru_r    <= err_fru_i;
      syn_r    <= err_syn_i;
    end else if (err_valid_i) begin
      ovf_r <= 1'b1;
    end else begin
      valid_r <= valid_r && !clr_valid;
      ovf_r   <= ovf_r && !clr_ovf;
    end
  end

  // saturating error counter, writable by software; a capture wins over a write
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_r <= eraf_pkg::WORD_ZERO;
    end else if (err_valid_i) begin
      count_r <= (&count_r) ? count_r : count_r + 32'h0000_0001;
    end else if (wr_count) begin
      count_r <= hwdata_i;
    end
  end

  // mode control, root writes only; filtering by default
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_r <= eraf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata_i[eraf_pkg::CTRL_TRAP_BIT:eraf_pkg::CTRL_ROOTONLY_BIT];
    end
  end

  // bus outputs
  assign hreadyout_o = (state_r != eraf_pkg::ST_RDWAIT);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_r;
  assign root_only_o = root_only;
  assign trap_ctrl_o = trap_on;

  // checks on the returned read data, blocked and non-root writes, the read wait and the counter step
  wire rd_done = (state_r == eraf_pkg::ST_RDDONE);

  property p_root_data;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && is_root && hit_data) |-> (hrdata_o == $past(data_r));
  endproperty
  a_root_data: assert property (p_root_data) else $error("root read of data was filtered");

  property p_ns_hides;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && (a_sec_r == eraf_pkg::SEC_NONSEC) && hit_data && ($past(space_r) != eraf_pkg::SEC_NONSEC))
      |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_ns_hides: assert property (p_ns_hides) else $error("non-secure read exposed other data");

  property p_sec_hides;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && (a_sec_r == eraf_pkg::SEC_SECURE) && hit_ctx
      && (($past(origin_r) == eraf_pkg::SEC_REALM) || ($past(origin_r) == eraf_pkg::SEC_ROOT)))
      |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_sec_hides: assert property (p_sec_hides) else $error("secure read exposed realm or root context");

  property p_realm_hides;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && (a_sec_r == eraf_pkg::SEC_REALM) && hit_data
      && (($past(space_r) == eraf_pkg::SEC_SECURE) || ($past(space_r) == eraf_pkg::SEC_ROOT)))
      |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_realm_hides: assert property (p_realm_hides) else $error("realm read exposed secure or root data");

  property p_addr_open;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_addr && !blk) |-> (hrdata_o == $past(addr_r));
  endproperty
  a_addr_open: assert property (p_addr_open) else $error("error address was withheld");

  property p_fru_open;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_misc && !blk) |-> (hrdata_o[15:0] == $past(fru_r));
  endproperty
  a_fru_open: assert property (p_fru_open) else $error("unit information was withheld");

  property p_count_open;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_count && !blk) |-> (hrdata_o == $past(count_r));
  endproperty
  a_count_open: assert property (p_count_open) else $error("error counter was withheld");

  property p_gpt_hides;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_data && !is_root && $past(gpt_r)) |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_gpt_hides: assert property (p_gpt_hides) else $error("protected memory data was exposed");

  property p_trap_blocks;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && a_sys_r && !is_root && $past(trap_on) && !hit_ctrl) |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_trap_blocks: assert property (p_trap_blocks) else $error("trapped access returned data");

  property p_blocked_write;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((state_r == eraf_pkg::ST_WRITE) && blk && hit_count && !err_valid_i) |=> (count_r == $past(count_r));
  endproperty
  a_blocked_write: assert property (p_blocked_write) else $error("blocked write changed the counter");

  property p_rootonly_mmio;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && $past(root_only) && !a_sys_r && !is_root && !hit_ctrl) |-> (hrdata_o == eraf_pkg::WORD_ZERO);
  endproperty
  a_rootonly_mmio: assert property (p_rootonly_mmio) else $error("root-only mode returned data");

  property p_read_wait;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (acc && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read did not take exactly one wait cycle");

  property p_node_open;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_node && !blk) |-> (hrdata_o == NODE_ID);
  endproperty
  a_node_open: assert property (p_node_open) else $error("node identification was withheld");

  property p_syn_hides;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_misc && !is_root && ($past(origin_r) != a_sec_r) && ($past(origin_r) != eraf_pkg::SEC_NONSEC))
      |-> (hrdata_o[eraf_pkg::MISC_SYN_LSB +: eraf_pkg::HALF_W] == 16'h0000);
  endproperty
  a_syn_hides: assert property (p_syn_hides) else $error("syndrome of another state was exposed");

  property p_stat_open;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (rd_done && hit_stat && !blk)
      |-> (hrdata_o[eraf_pkg::STAT_VALID_BIT] == $past(valid_r))
          && (hrdata_o[eraf_pkg::STAT_SEV_LSB +: eraf_pkg::SEV_W] == $past(sev_r));
  endproperty
  a_stat_open: assert property (p_stat_open) else $error("status contents were withheld");

  property p_ctrl_kept;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    ((state_r == eraf_pkg::ST_WRITE) && hit_ctrl && !is_root) |=> (ctrl_r == $past(ctrl_r));
  endproperty
  a_ctrl_kept: assert property (p_ctrl_kept) else $error("non-root write changed the mode control");

  property p_count_step;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
    (err_valid_i && !(&count_r)) |=> (count_r == $past(count_r) + 32'h0000_0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("error counter did not step on capture");

endmodule

// ---- common/eraf_pkg.sv ----
package eraf_pkg;

  // requester and origin security state encodings
  localparam logic [1:0] SEC_SECURE = 2'h0;
  localparam logic [1:0] SEC_NONSEC = 2'h1;
  localparam logic [1:0] SEC_ROOT   = 2'h2;
  localparam logic [1:0] SEC_REALM  = 2'h3;

  // register byte offsets (low address byte)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_MISC   = 8'h08;
  localparam logic [7:0] OFS_COUNT  = 8'h0c;
  localparam logic [7:0] OFS_DATA   = 8'h10;
  localparam logic [7:0] OFS_CTX    = 8'h14;
  localparam logic [7:0] OFS_NODE   = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1c;
  localparam int         OFS_W      = 8;

  // status register fields
  localparam int STAT_VALID_BIT = 0;
  localparam int STAT_OVF_BIT   = 1;
  localparam int STAT_SEV_LSB   = 4;
  localparam int SEV_W          = 3;
  localparam int STAT_SPACE_LSB = 8;
  localparam int STAT_STATE_LSB = 10;
  localparam int STAT_GPT_BIT   = 12;

  // miscellaneous register fields
  localparam int MISC_FRU_LSB = 0;
  localparam int MISC_SYN_LSB = 16;
  localparam int HALF_W       = 16;

  // control register fields and reset value (content filtering by default)
  localparam int          CTRL_ROOTONLY_BIT = 0;
  localparam int          CTRL_TRAP_BIT     = 1;
  localparam logic [1:0]  CTRL_RST          = 2'h0;

  // bus constants
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

  // bus slave states
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_WRITE  = 4'h2,
    ST_RDWAIT = 4'h4,
    ST_RDDONE = 4'h8
  } eraf_state_t;

endpackage

// ---- verif/eraf_req_model.sv ----
`timescale 1ns/100ps
// requester model: one ahb-lite master issuing tagged single-word transfers
module eraf_req_model (
  input  wire logic        ref_clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic [31:0]      haddr_o,
  output logic [1:0]       htrans_o,
  output logic             hwrite_o,
  output logic [2:0]       hsize_o,
  output logic [31:0]      hwdata_o,
  output logic [1:0]       req_sec_o,
  output logic             req_sysreg_o
);
  // idle bus at time zero
  initial begin
    hsel_o       = 1'b0;
    haddr_o      = 32'h0000_0000;
    htrans_o     = 2'h0;
    hwrite_o     = 1'b0;
    hsize_o      = 3'h2;
    hwdata_o     = 32'hffff_ffff;
    req_sec_o    = 2'h2;
    req_sysreg_o = 1'b0;
  end

  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] s, input logic sy, output logic [31:0] q);
    @(posedge ref_clk_i);
    hsel_o       <= 1'b1;
    htrans_o     <= eraf_pkg::HTRANS_NONSEQ;
    haddr_o      <= {24'h00_0000, a};
    hwrite_o     <= w;
    hsize_o      <= eraf_pkg::HSIZE_WORD;
    req_sec_o    <= s;
    req_sysreg_o <= sy;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge ref_clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
    hwdata_o <= ~d; // released data no longer shows the last value
  endtask
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/100ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb;
  localparam logic [31:0] NODE  = 32'h0000_0a5c; // arbitrary node identification value
  localparam logic [31:0] EADDR = 32'h8000_1234;
  localparam logic [31:0] ECTX  = 32'h3333_4444;
  localparam logic [15:0] EFRU  = 16'h00a5;
  localparam logic [15:0] ESYN  = 16'h5a5a;
  localparam logic [2:0]  ESEV  = 3'h5;
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        ev = 1'b0, eg = 1'b0, hsel, hwrite, hready, hresp, sysreg, ronly, trap;
  logic [1:0]  esp = 2'h0, est = 2'h0, htrans, sec;
  logic [2:0]  hsize, esev = 3'h0;
  logic [15:0] efru = 16'h0, esyn = 16'h0;
  logic [31:0] ea = 32'h0, ed = 32'h0, ec = 32'h0, haddr, hwdata, hrdata, q;
  int          error_cnt = 0;
  int          checked = 0;

  // free-running clock
  always #25 ref_clk_i = ~ref_clk_i;

  eraf_req_model m (.ref_clk_i(ref_clk_i), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel), .haddr_o(haddr),
    .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata), .req_sec_o(sec), .req_sysreg_o(sysreg));

  eraf_filter #(.NODE_ID(NODE)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .req_sec_i(sec), .req_sysreg_i(sysreg),
    .err_valid_i(ev), .err_addr_i(ea), .err_data_i(ed), .err_ctx_i(ec), .err_space_i(esp), .err_state_i(est),
    .err_gpt_deny_i(eg), .err_fru_i(efru), .err_syn_i(esyn), .err_sev_i(esev), .root_only_o(ronly),
    .trap_ctrl_o(trap));

  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // owner visible to requester
  function automatic logic vis(input logic [1:0] o, input logic [1:0] r);
    return (r == eraf_pkg::SEC_ROOT) || (o == r) || (o == eraf_pkg::SEC_NONSEC);
  endfunction

  // one-cycle error capture pulse, contents other than space, state and gpt flag scrambled outside it
  task automatic cap(input logic [1:0] sp, input logic [1:0] st, input logic g, input logic [31:0] d);
    @(posedge ref_clk_i);
    ev <= 1'b1; ea <= EADDR; ed <= d; ec <= ECTX; esp <= sp; est <= st; eg <= g;
    efru <= EFRU; esyn <= ESYN; esev <= ESEV;
    @(posedge ref_clk_i);
    ev <= 1'b0; ea <= ~EADDR; ed <= ~d; ec <= ~ECTX; efru <= ~EFRU; esyn <= ~ESYN; esev <= ~ESEV;
  endtask

  // read every record register from each requester state
  task automatic chk_all(input logic [1:0] sp, input logic [1:0] st, input logic g, input logic [31:0] d,
                         input logic [31:0] cnt, input logic ovf);
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      r = i[1:0];
      m.xfer(1'b0, eraf_pkg::OFS_STATUS, 32'h0, r, 1'b0, q);
      `CHK("status", {19'h0, g, st, sp, 1'b0, ESEV, 2'b00, ovf, 1'b1}, q)
      m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, r, 1'b0, q);
      `CHK("addr", EADDR, q)
      m.xfer(1'b0, eraf_pkg::OFS_MISC, 32'h0, r, 1'b0, q);
      `CHK("misc", {vis(st, r) ? ESYN : 16'h0, EFRU}, q)
      m.xfer(1'b0, eraf_pkg::OFS_COUNT, 32'h0, r, 1'b0, q);
      `CHK("count", cnt, q)
      m.xfer(1'b0, eraf_pkg::OFS_DATA, 32'h0, r, 1'b0, q);
      `CHK("data", (vis(sp, r) && (r == eraf_pkg::SEC_ROOT || !g)) ? d : 32'h0, q)
      m.xfer(1'b0, eraf_pkg::OFS_CTX, 32'h0, r, 1'b0, q);
      `CHK("ctx", vis(st, r) ? ECTX : 32'h0, q)
      m.xfer(1'b0, eraf_pkg::OFS_NODE, 32'h0, r, 1'b0, q);
      `CHK("node", NODE, q)
    end
  endtask

  // reset state and register defaults
  task automatic t_reset;
    m.xfer(1'b0, eraf_pkg::OFS_CTRL, 32'h0, eraf_pkg::SEC_ROOT, 1'b0, q);
    `CHK("ctrl", 32'h0, q)
    m.xfer(1'b0, eraf_pkg::OFS_STATUS, 32'h0, eraf_pkg::SEC_NONSEC, 1'b0, q);
    `CHK("status0", {20'h0, eraf_pkg::SEC_NONSEC, eraf_pkg::SEC_NONSEC, 8'h00}, q)
    `CHK("modes0", 2'b00, {ronly, trap})
  endtask

  // capture, overflow, clear and filtering per requester state
  task automatic t_filter;
    cap(eraf_pkg::SEC_SECURE, eraf_pkg::SEC_REALM, 1'b0, 32'h1111_2222);
    chk_all(eraf_pkg::SEC_SECURE, eraf_pkg::SEC_REALM, 1'b0, 32'h1111_2222, 32'h1, 1'b0);
    cap(eraf_pkg::SEC_NONSEC, eraf_pkg::SEC_ROOT, 1'b1, 32'h5555_6666);
    chk_all(eraf_pkg::SEC_SECURE, eraf_pkg::SEC_REALM, 1'b0, 32'h1111_2222, 32'h2, 1'b1);
    m.xfer(1'b1, eraf_pkg::OFS_STATUS, 32'h3, eraf_pkg::SEC_ROOT, 1'b0, q);
    cap(eraf_pkg::SEC_NONSEC, eraf_pkg::SEC_ROOT, 1'b1, 32'h5555_6666);
    chk_all(eraf_pkg::SEC_NONSEC, eraf_pkg::SEC_ROOT, 1'b1, 32'h5555_6666, 32'h3, 1'b0);
  endtask

  // root-only and trap blocking modes
  task automatic t_modes;
    m.xfer(1'b1, eraf_pkg::OFS_CTRL, 32'h3, eraf_pkg::SEC_NONSEC, 1'b0, q);
    #1 `CHK("ctrl_nonroot", 2'b00, {ronly, trap})
    m.xfer(1'b1, eraf_pkg::OFS_CTRL, 32'h1, eraf_pkg::SEC_ROOT, 1'b0, q);
    #1 `CHK("rootonly", 2'b10, {ronly, trap})
    m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, eraf_pkg::SEC_NONSEC, 1'b0, q);
    `CHK("mmio_block", 32'h0, q)
    m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, eraf_pkg::SEC_NONSEC, 1'b1, q);
    `CHK("sys_open", EADDR, q)
    m.xfer(1'b1, eraf_pkg::OFS_STATUS, 32'h3, eraf_pkg::SEC_SECURE, 1'b0, q);
    m.xfer(1'b0, eraf_pkg::OFS_STATUS, 32'h0, eraf_pkg::SEC_ROOT, 1'b0, q);
    `CHK("no_side_eff", {19'h0, 1'b1, eraf_pkg::SEC_ROOT, eraf_pkg::SEC_NONSEC, 1'b0, ESEV, 2'b00, 1'b0, 1'b1}, q)
    m.xfer(1'b1, eraf_pkg::OFS_CTRL, 32'h2, eraf_pkg::SEC_ROOT, 1'b0, q);
    #1 `CHK("trap", 2'b01, {ronly, trap})
    m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, eraf_pkg::SEC_REALM, 1'b1, q);
    `CHK("sys_block", 32'h0, q)
    m.xfer(1'b1, eraf_pkg::OFS_COUNT, 32'h0, eraf_pkg::SEC_REALM, 1'b1, q);
    m.xfer(1'b0, eraf_pkg::OFS_COUNT, 32'h0, eraf_pkg::SEC_ROOT, 1'b0, q);
    `CHK("count_kept", 32'h0000_0003, q)
    m.xfer(1'b1, eraf_pkg::OFS_COUNT, 32'h0000_0010, eraf_pkg::SEC_ROOT, 1'b0, q);
    m.xfer(1'b0, eraf_pkg::OFS_COUNT, 32'h0, eraf_pkg::SEC_ROOT, 1'b0, q);
    `CHK("count_wr", 32'h0000_0010, q)
    m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, eraf_pkg::SEC_REALM, 1'b0, q);
    `CHK("mmio_open", EADDR, q)
    m.xfer(1'b0, eraf_pkg::OFS_ADDR, 32'h0, eraf_pkg::SEC_ROOT, 1'b1, q);
    `CHK("root_sys", EADDR, q)
    m.xfer(1'b0, 8'h20, 32'h0, eraf_pkg::SEC_ROOT, 1'b0, q);
    `CHK("unmapped", 32'h0, q)
    `CHK("hresp", 1'b0, hresp)
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_filter();
    t_modes();
    give_verdict();
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    give_verdict();
  end
endmodule
